// >>> logic/test_access_port.sv
// Contract
// - scan-side test logic runs on scan clock; device-side handshake, status capture and DEV_CTRL run on MCLK
// - shift latest captured results out serially
// - mode-select steps 16-state controller
// - data-in shifts into selected scan path
// - scan reset clears controller asynchronously
// - scan reset leaves device registers unchanged
`default_nettype none
module test_access_port #(
  parameter logic [31:0] ID_CODE = tap_pkg::ID_DEFAULT
) (
  input  wire logic                       MCLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       SCAN_CLK,
  input  wire logic                       SCAN_RESET_N,
  input  wire logic                       SCAN_MODE,
  input  wire logic                       SCAN_DIN,
  output logic                            SCAN_DOUT,
  output logic                            SCAN_DOUT_OE,
  input  wire logic [tap_pkg::WORD_W-1:0] DEV_STATUS,
  output logic      [tap_pkg::WORD_W-1:0] DEV_CTRL
);
  import tap_pkg::*;

  tap_state_t         state;
  logic [IR_W-1:0]    ir;
  logic [IR_W-1:0]    ir_shift;
  logic [DR_W-1:0]    dr_shift;
  logic [DR_W-1:0]    next_dr;
  logic [WORD_W-1:0]  ctrl_shadow;
  logic [WORD_W-1:0]  status_hold;
  logic               ctrl_req;
  logic               stat_req;
  logic               stat_done;
  logic               ctrl_ack_s1, ctrl_ack_s2;
  logic               stat_ack_s1, stat_ack_s2;
  logic               ctrl_req_s1, ctrl_req_s2, ctrl_ack;
  logic               stat_req_s1, stat_req_s2, stat_ack;
  logic               ctrl_load;

  function automatic int dr_len(input logic [IR_W-1:0] code);
    unique case (code)
      INS_IDCODE: dr_len = LEN_ID;
      INS_STATUS: dr_len = LEN_STATUS;
      INS_CTRL:   dr_len = LEN_CTRL;
      default:    dr_len = LEN_BYPASS;
    endcase
  endfunction : dr_len

  tap_fsm u_fsm (
    .tck          (SCAN_CLK),
    .scan_reset_n (SCAN_RESET_N),
    .tms          (SCAN_MODE),
    .state        (state)
  );

  // instruction path, all on the scan clock
  always_ff @(posedge SCAN_CLK) begin
    unique case (state)
      CAP_IR:  ir_shift <= IR_CAPTURE;
      SH_IR:   ir_shift <= {SCAN_DIN, ir_shift[IR_W-1:1]};
      default: ir_shift <= ir_shift;
    endcase
  end

  always_ff @(posedge SCAN_CLK) begin
    if (state == TLR) begin
      ir <= INS_IDCODE;
    end else if (state == UPD_IR) begin
      ir <= ir_shift;
    end
  end

  // data path: new bit enters at the top of the selected length
  always_comb begin
    next_dr = dr_shift;
    unique case (state)
      CAP_DR: begin
        unique case (ir)
          INS_IDCODE: next_dr = ID_CODE;
          INS_STATUS: next_dr = {{(DR_W-LEN_STATUS){1'b0}}, stat_done, status_hold};
          INS_CTRL:   next_dr = {{(DR_W-WORD_W){1'b0}}, ctrl_shadow};
          default:    next_dr = '0;
        endcase
      end
      SH_DR: begin
        next_dr = dr_shift >> 1;
        next_dr[dr_len(ir)-1] = SCAN_DIN;
      end
      default: next_dr = dr_shift;
    endcase
  end

  always_ff @(posedge SCAN_CLK) begin
    dr_shift <= next_dr;
  end

  // word frozen while a load is in flight so the system side reads it settled
  always_ff @(posedge SCAN_CLK) begin
    if (state == UPD_DR && ir == INS_CTRL && !ctrl_req && !ctrl_ack_s2) begin
      ctrl_shadow <= dr_shift[WORD_W-1:0];
    end
  end

  // output driven on the falling edge so the tester samples a settled bit
  always_ff @(negedge SCAN_CLK or negedge SCAN_RESET_N) begin
    if (!SCAN_RESET_N) begin
      SCAN_DOUT    <= 1'b0;
      SCAN_DOUT_OE <= 1'b0;
    end else begin
      SCAN_DOUT    <= (state == SH_IR) ? ir_shift[0] : dr_shift[0];
      SCAN_DOUT_OE <= (state == SH_IR) || (state == SH_DR);
    end
  end

  // four-phase handshakes: a scan reset drops a request, never fakes one
  always_ff @(posedge SCAN_CLK or negedge SCAN_RESET_N) begin
    if (!SCAN_RESET_N) begin
      ctrl_ack_s1 <= 1'b0;
      ctrl_ack_s2 <= 1'b0;
      stat_ack_s1 <= 1'b0;
      stat_ack_s2 <= 1'b0;
    end else begin
      ctrl_ack_s1 <= ctrl_ack;
      ctrl_ack_s2 <= ctrl_ack_s1;
      stat_ack_s1 <= stat_ack;
      stat_ack_s2 <= stat_ack_s1;
    end
  end

  always_ff @(posedge SCAN_CLK or negedge SCAN_RESET_N) begin
    if (!SCAN_RESET_N) begin
      ctrl_req <= 1'b0;
    end else if (state == UPD_DR && ir == INS_CTRL && !ctrl_ack_s2) begin
      ctrl_req <= 1'b1;
    end else if (ctrl_ack_s2) begin
      ctrl_req <= 1'b0;
    end
  end

  // limitation: a snapshot asked while the previous one is in flight is dropped
  always_ff @(posedge SCAN_CLK or negedge SCAN_RESET_N) begin
    if (!SCAN_RESET_N) begin
      stat_req  <= 1'b0;
      stat_done <= 1'b0;
    end else if (state == UPD_IR && ir_shift == INS_STATUS && !stat_req && !stat_ack_s2) begin
      stat_req  <= 1'b1;
      stat_done <= 1'b0;
    end else if (stat_req && stat_ack_s2) begin
      stat_req  <= 1'b0;
      stat_done <= 1'b1;
    end
  end

  // device side on MCLK
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_req_s1 <= 1'b0;
      ctrl_req_s2 <= 1'b0;
      ctrl_ack    <= 1'b0;
      stat_req_s1 <= 1'b0;
      stat_req_s2 <= 1'b0;
      stat_ack    <= 1'b0;
    end else begin
      ctrl_req_s1 <= ctrl_req;
      ctrl_req_s2 <= ctrl_req_s1;
      ctrl_ack    <= ctrl_req_s2;
      stat_req_s1 <= stat_req;
      stat_req_s2 <= stat_req_s1;
      stat_ack    <= stat_req_s2;
    end
  end

  assign ctrl_load = ctrl_req_s2 && !ctrl_ack;

  // only the system reset clears this; the scan reset never reaches it
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      DEV_CTRL <= CTRL_RESET;
    end else if (ctrl_load) begin
      DEV_CTRL <= ctrl_shadow;
    end
  end

  always_ff @(posedge MCLK) begin
    if (stat_req_s2 && !stat_ack) begin
      status_hold <= DEV_STATUS;
    end
  end

  sequence shift_dr_bypass;
    state == SH_DR && ir == INS_BYPASS;
  endsequence

  chk_ir_update_load: assert property (@(posedge SCAN_CLK) disable iff (!SCAN_RESET_N)
    state == UPD_IR |=> ir == $past(ir_shift))
    else $error("instruction not loaded from shift stage on update");

  chk_dout_shift_bit: assert property (@(posedge SCAN_CLK) disable iff (!SCAN_RESET_N)
    (state == SH_DR && SCAN_DOUT_OE) |-> SCAN_DOUT == dr_shift[0])
    else $error("data output does not show the low scan bit");

  chk_dout_ir_bit: assert property (@(posedge SCAN_CLK) disable iff (!SCAN_RESET_N)
    (state == SH_IR && SCAN_DOUT_OE) |-> SCAN_DOUT == ir_shift[0])
    else $error("data output does not show the low instruction bit");

  chk_ctrl_shadow_load: assert property (@(posedge SCAN_CLK) disable iff (!SCAN_RESET_N)
    (state == UPD_DR && ir == INS_CTRL && !ctrl_req && !ctrl_ack_s2)
      |=> ctrl_shadow == $past(dr_shift[WORD_W-1:0]))
    else $error("control word not taken from scan path on update");

  chk_din_bypass: assert property (@(posedge SCAN_CLK) disable iff (!SCAN_RESET_N)
    shift_dr_bypass |=> dr_shift[0] == $past(SCAN_DIN))
    else $error("data input not shifted into bypass stage");

  chk_ctrl_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !ctrl_load |=> $stable(DEV_CTRL))
    else $error("device control changed without a scan update");

  chk_dout_enable: assert property (@(posedge SCAN_CLK) disable iff (!SCAN_RESET_N)
    (state == SH_DR) ##1 (state == SH_DR) |-> SCAN_DOUT_OE)
    else $error("output enable not raised on falling edge in shift");

endmodule : test_access_port
`default_nettype wire

// >>> inc/tap_pkg.sv
`default_nettype none
package tap_pkg;
  localparam int          IR_W        = 4;
  localparam int          DR_W        = 32;
  localparam int          WORD_W      = 16;
  localparam int          LEN_BYPASS  = 1;
  localparam int          LEN_ID      = 32;
  localparam int          LEN_STATUS  = WORD_W + 1;
  localparam int          LEN_CTRL    = WORD_W;
  localparam logic [3:0]  INS_IDCODE  = 4'h1;
  localparam logic [3:0]  INS_STATUS  = 4'h2;
  localparam logic [3:0]  INS_CTRL    = 4'h3;
  localparam logic [3:0]  INS_BYPASS  = 4'hf;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  // identity value is arbitrary; bit 0 set as a scan identity word requires
  localparam logic [31:0] ID_DEFAULT  = 32'h0000_0001;

  // gray codes along capture-shift-update paths, except CAP_DR to EX1_DR, EX1_DR to UPD_DR, CAP_IR to EX1_IR and EX2_IR to SH_IR
  typedef enum logic [3:0] {
    TLR    = 4'h0,
    RTI    = 4'h1,
    SEL_DR = 4'h3,
    CAP_DR = 4'h2,
    SH_DR  = 4'h6,
    EX1_DR = 4'h7,
    PAU_DR = 4'h5,
    EX2_DR = 4'h4,
    UPD_DR = 4'hc,
    SEL_IR = 4'hd,
    CAP_IR = 4'hf,
    SH_IR  = 4'he,
    EX1_IR = 4'ha,
    PAU_IR = 4'hb,
    EX2_IR = 4'h9,
    UPD_IR = 4'h8
  } tap_state_t;
endpackage : tap_pkg
`default_nettype wire

// >>> logic/tap_fsm.sv
`default_nettype none
module tap_fsm (
  input  wire logic               tck,
  input  wire logic               scan_reset_n,
  input  wire logic               tms,
  output tap_pkg::tap_state_t     state
);
  import tap_pkg::*;

  tap_state_t next_state;

  // asynchronous clear of this controller; the scan reset also clears the output and scan-side handshake flops
  always_ff @(posedge tck or negedge scan_reset_n) begin
    if (!scan_reset_n) begin
      state <= TLR;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    unique case (state)
      TLR:    next_state = tms ? TLR    : RTI;
      RTI:    next_state = tms ? SEL_DR : RTI;
      SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
      CAP_DR: next_state = tms ? EX1_DR : SH_DR;
      SH_DR:  next_state = tms ? EX1_DR : SH_DR;
      EX1_DR: next_state = tms ? UPD_DR : PAU_DR;
      PAU_DR: next_state = tms ? EX2_DR : PAU_DR;
      EX2_DR: next_state = tms ? UPD_DR : SH_DR;
      UPD_DR: next_state = tms ? SEL_DR : RTI;
      SEL_IR: next_state = tms ? TLR    : CAP_IR;
      CAP_IR: next_state = tms ? EX1_IR : SH_IR;
      SH_IR:  next_state = tms ? EX1_IR : SH_IR;
      EX1_IR: next_state = tms ? UPD_IR : PAU_IR;
      PAU_IR: next_state = tms ? EX2_IR : PAU_IR;
      EX2_IR: next_state = tms ? UPD_IR : SH_IR;
      UPD_IR: next_state = tms ? SEL_DR : RTI;
    endcase
  end

  sequence five_ones;
    tms [*5];
  endsequence

  chk_tms_reset_walk: assert property (@(posedge tck) disable iff (!scan_reset_n)
    five_ones |=> state == TLR)
    else $error("five mode-select highs did not reach test-logic-reset");

  chk_trst_async_clear: assert property (@(posedge tck) disable iff (1'b0)
    !scan_reset_n |-> state == TLR)
    else $error("controller not cleared while scan reset held");

endmodule : tap_fsm
`default_nettype wire

// >>> verification/scan_host.sv
`default_nettype none
module scan_host (
  output logic      scan_clk,
  output logic      scan_mode,
  output logic      scan_din,
  input  wire logic scan_dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic q_bit;
  initial begin
    scan_clk  = 1'b0; // parked low between frames
    scan_mode = 1'b1;
    scan_din  = 1'b1;
  end
  // one period: drive after falling edge, sample at rising edge
  task automatic tick(input logic m, input logic d);
    scan_mode = m;
    scan_din  = d;
    #80 scan_clk = 1'b1;
    q_bit = scan_dout;
    #80 scan_clk = 1'b0;
  endtask : tick
  // from idle through capture, shift and update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    q = '0;
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i]);
      q[i] = q_bit;
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask : scan
endmodule : scan_host
`default_nettype wire

// >>> verification/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tap_pkg::*;
  localparam logic [31:0] ID_TB = 32'h5a3c_0e71; // arbitrary identity value
  logic              mclk, sys_rst, rst_n, sclk, smode, sdin, sdout, soe;
  logic [WORD_W-1:0] dev_status, dev_ctrl;
  logic [31:0]       rng, got, q;
  logic [31:0]       expq[$];
  int                fail_count, cmp_count;
  event              res_ev;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  test_access_port #(.ID_CODE(ID_TB)) i_test_access_port (.MCLK(mclk), .SYS_RST(sys_rst),
    .SCAN_CLK(sclk), .SCAN_RESET_N(rst_n), .SCAN_MODE(smode), .SCAN_DIN(sdin),
    .SCAN_DOUT(sdout), .SCAN_DOUT_OE(soe), .DEV_STATUS(dev_status), .DEV_CTRL(dev_ctrl));
  scan_host i_scan_host (.scan_clk(sclk), .scan_mode(smode), .scan_din(sdin),
    .scan_dout(sdout));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // results are handed to the watcher, which pairs them with the oldest note
  task automatic seen(input logic [31:0] v);
    got = v;
    ->res_ev;
    #1;
  endtask : seen

  always @(res_ev) begin
    check(got, expq.size() > 0 ? expq.pop_front() : 'x);
  end

  task automatic xfer(input logic ir, input int n, input logic [31:0] d, input logic [31:0] e);
    expq.push_back(e);
    i_scan_host.scan(ir, n, d, q);
    seen(q);
  endtask : xfer

  // load crosses into the system domain; bounded wait
  task automatic wait_ctrl(input logic [15:0] e);
    int i;
    expq.push_back({16'h0, e});
    for (i = 0; i < 100 && dev_ctrl !== e; i++) @(negedge mclk);
    if (i == 100) begin
      fail_count++;
      test_done();
    end
    seen({16'h0, dev_ctrl});
  endtask : wait_ctrl

  initial begin
    rng = 32'h8474b2d5;
    sys_rst = 1'b1;
    rst_n = 1'b1;
    dev_status = '0;
    // a clean falling edge so the asynchronous clear is seen for sure
    #1 rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    rst_n = 1'b1;
    wait_ctrl(CTRL_RESET);
    #3 i_scan_host.tick(1'b0, 1'b1);
    xfer(1'b0, LEN_ID, '0, ID_TB);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 4, {28'h0, k == 0 ? INS_BYPASS : 4'h7}, {28'h0, IR_CAPTURE});
      rng = xs(rng);
      xfer(1'b0, 8, rng, {24'h0, rng[6:0], 1'b0});
    end
    xfer(1'b1, 4, {28'h0, INS_CTRL}, {28'h0, IR_CAPTURE});
    repeat (2) begin
      rng = xs(rng);
      i_scan_host.scan(1'b0, LEN_CTRL, rng, q);
      wait_ctrl(rng[15:0]);
      repeat (4) i_scan_host.tick(1'b0, 1'b1);
    end
    xfer(1'b0, LEN_CTRL, rng, {16'h0, rng[15:0]});
    // park in shift, then pull scan reset with the clock stopped
    i_scan_host.tick(1'b1, 1'b1);
    i_scan_host.tick(1'b0, 1'b1);
    i_scan_host.tick(1'b0, 1'b1);
    #1 expq.push_back(32'h1);
    seen({31'h0, soe});
    rst_n = 1'b0;
    #2 expq.push_back(32'h0);
    seen({30'h0, soe, sdout});
    i_scan_host.tick(1'b1, 1'b1);
    repeat (20) @(negedge mclk);
    wait_ctrl(rng[15:0]);
    rst_n = 1'b1;
    i_scan_host.tick(1'b0, 1'b1);
    rng = xs(rng);
    @(negedge mclk) dev_status = rng[15:0];
    xfer(1'b1, 4, {28'h0, INS_STATUS}, {28'h0, IR_CAPTURE});
    repeat (6) i_scan_host.tick(1'b0, 1'b1);
    xfer(1'b0, LEN_STATUS, '0, {15'h0, 1'b1, dev_status});
    repeat (5) i_scan_host.tick(1'b1, 1'b1);
    i_scan_host.tick(1'b0, 1'b1);
    xfer(1'b0, LEN_ID, '0, ID_TB);
    test_done();
  end
endmodule : tb
`default_nettype wire
